/* File: src/dmsp_pkg.sv */
// dmsp_pkg: shared constants and types for the dual-mode stack pointer
package dmsp_pkg;

    // ********************************************************
    // widths and register numbers
    // ********************************************************
    localparam int unsigned DMSP_WORD_W = 16;
    localparam int unsigned DMSP_REG_W = 4;
    localparam logic [3:0] DMSP_STACK_WORD_REG = 4'hf;
    localparam logic [3:0] DMSP_STACK_SEG_REG = 4'he;
    localparam logic [15:0] DMSP_RESET_SP = 16'h0000;
    localparam logic [15:0] DMSP_RESET_SEG = 16'h0000;
    localparam logic [15:0] DMSP_WORD_SIZE = 16'h0002;
    localparam logic [15:0] DMSP_LONG_SIZE = 16'h0004;

    // ********************************************************
    // bus status codes
    // ********************************************************
    localparam logic [3:0] DMSP_ST_IDLE = 4'h0;
    localparam logic [3:0] DMSP_ST_DATA = 4'ha;
    localparam logic [3:0] DMSP_ST_STACK = 4'hb;

    // ********************************************************
    // operations
    // ********************************************************
    typedef enum logic [3:0] {
        DMSP_OP_NONE,
        DMSP_OP_PUSH,
        DMSP_OP_POP,
        DMSP_OP_CALL,
        DMSP_OP_RET,
        DMSP_OP_TRAP,
        DMSP_OP_MEM,
        DMSP_OP_REG_WR,
        DMSP_OP_LDCTL_WR
    } dmsp_op_t;

    typedef enum logic [1:0] {
        DMSP_SEL_OFFSET,
        DMSP_SEL_SEGMENT,
        DMSP_SEL_WORD
    } dmsp_sel_t;

    typedef struct packed {
        dmsp_op_t op;
        logic long_op;
        logic [3:0] addr_reg;
        logic base_mode;
        dmsp_sel_t sel;
        logic [15:0] wdata;
        logic [15:0] addr_in;
    } dmsp_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic stack_ref;
        logic [15:0] seg;
        logic [15:0] addr;
        logic [3:0] status;
    } dmsp_bus_t;

endpackage : dmsp_pkg

/* File: src/dmsp_sp_bank.sv */
// dmsp_sp_bank: the two banked copies of the implicit stack pointer
`timescale 1ns/1ps
`default_nettype none
module dmsp_sp_bank #(
    parameter int unsigned W = 16
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic wr_sys_i,
    input wire logic wr_norm_i,
    input wire logic wr_seg_i,
    input wire logic [W-1:0] off_i,
    input wire logic [W-1:0] seg_i,
    output logic [W-1:0] sys_off_o,
    output logic [W-1:0] sys_seg_o,
    output logic [W-1:0] norm_off_o,
    output logic [W-1:0] norm_seg_o
);
    import dmsp_pkg::*;

    // ********************************************************
    // privileged copy
    // ********************************************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sys_off_o <= W'(DMSP_RESET_SP);
            sys_seg_o <= W'(DMSP_RESET_SEG);
        end else if (ce_i && wr_sys_i) begin
            sys_off_o <= off_i;
            if (wr_seg_i) begin
                sys_seg_o <= seg_i;
            end
        end
    end

    // ********************************************************
    // unprivileged copy
    // ********************************************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            norm_off_o <= W'(DMSP_RESET_SP);
            norm_seg_o <= W'(DMSP_RESET_SEG);
        end else if (ce_i && wr_norm_i) begin
            norm_off_o <= off_i;
            if (wr_seg_i) begin
                norm_seg_o <= seg_i;
            end
        end
    end
endmodule : dmsp_sp_bank
`default_nettype wire

/* File: src/dmsp_status_enc.sv */
// dmsp_status_enc: stack versus data reference classification
`timescale 1ns/1ps
`default_nettype none
module dmsp_status_enc (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic access_i,
    input wire logic stack_via_sp_i,
    output logic [3:0] status_o,
    output logic stack_ref_o
);
    import dmsp_pkg::*;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            status_o <= DMSP_ST_IDLE;
            stack_ref_o <= 1'b0;
        end else if (ce_i) begin
            stack_ref_o <= access_i && stack_via_sp_i;
            if (!access_i) begin
                status_o <= DMSP_ST_IDLE;
            end else if (stack_via_sp_i) begin
                status_o <= DMSP_ST_STACK;
            end else begin
                status_o <= DMSP_ST_DATA;
            end
        end
    end
endmodule : dmsp_status_enc
`default_nettype wire

/* File: src/dmsp_top.sv */
// dmsp_top: dual-mode implicit stack pointer with bus status
`timescale 1ns/1ps
`default_nettype none
module dmsp_top #(
    parameter int unsigned W = 16
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire dmsp_pkg::dmsp_req_t req_i,
    input wire logic privileged_i,
    input wire logic segmented_i,
    input wire logic boundary_i,
    input wire logic irq_i,
    output logic req_done_o,
    output logic req_err_o,
    output logic irq_ack_o,
    output dmsp_pkg::dmsp_bus_t bus_o,
    output logic [W-1:0] rdata_o
);
    import dmsp_pkg::*;

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [W-1:0] op_size(input logic long_op);
        return long_op ? W'(DMSP_LONG_SIZE) : W'(DMSP_WORD_SIZE);
    endfunction : op_size

    function automatic logic names_sp(input logic [3:0] r,
                                      input logic seg);
        return (r == DMSP_STACK_WORD_REG) ||
               (seg && r == DMSP_STACK_SEG_REG);
    endfunction : names_sp

    // ********************************************************
    // banked copies
    // ********************************************************
    logic [W-1:0] sys_off;
    logic [W-1:0] sys_seg;
    logic [W-1:0] norm_off;
    logic [W-1:0] norm_seg;
    logic wr_sys;
    logic wr_norm;
    logic wr_seg;
    logic [W-1:0] new_off;
    logic [W-1:0] new_seg;

    dmsp_sp_bank #(.W(W)) u_bank (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .wr_sys_i(wr_sys),
        .wr_norm_i(wr_norm),
        .wr_seg_i(wr_seg),
        .off_i(new_off),
        .seg_i(new_seg),
        .sys_off_o(sys_off),
        .sys_seg_o(sys_seg),
        .norm_off_o(norm_off),
        .norm_seg_o(norm_seg)
    );

    // ********************************************************
    // request decode
    // ********************************************************
    logic use_sys;
    logic [W-1:0] cur_off;
    logic [W-1:0] cur_seg;
    logic take;
    logic access;
    logic via_sp;
    logic bad;
    logic [W-1:0] acc_addr;
    logic [W-1:0] acc_seg;
    logic acc_wr;

    // trap entry forced onto privileged copy
    always_comb begin
        use_sys = privileged_i;
        if (req_i.op == DMSP_OP_TRAP) begin
            use_sys = 1'b1;
        end
    end

    assign cur_off = use_sys ? sys_off : norm_off;
    assign cur_seg = use_sys ? sys_seg : norm_seg;
    assign take = ce_i && req_valid_i;

    always_comb begin
        wr_sys = 1'b0;
        wr_norm = 1'b0;
        wr_seg = 1'b0;
        new_off = cur_off;
        new_seg = cur_seg;
        access = 1'b0;
        via_sp = 1'b0;
        bad = 1'b0;
        acc_addr = cur_off;
        acc_seg = segmented_i ? cur_seg : '0;
        acc_wr = 1'b0;
        case (req_i.op)
            DMSP_OP_PUSH, DMSP_OP_CALL, DMSP_OP_TRAP: begin
                new_off = cur_off - op_size(req_i.long_op);
                acc_addr = new_off;
                access = 1'b1;
                via_sp = 1'b1;
                acc_wr = 1'b1;
            end
            DMSP_OP_POP, DMSP_OP_RET: begin
                new_off = cur_off + op_size(req_i.long_op);
                access = 1'b1;
                via_sp = 1'b1;
            end
            DMSP_OP_MEM: begin
                access = 1'b1;
                acc_addr = req_i.addr_in;
                acc_wr = 1'b1;
                if (names_sp(req_i.addr_reg, segmented_i)
                        && req_i.base_mode) begin
                    via_sp = 1'b1;
                    acc_addr = cur_off + req_i.addr_in;
                end
            end
            DMSP_OP_REG_WR: begin
                if (req_i.addr_reg == DMSP_STACK_WORD_REG) begin
                    new_off = req_i.wdata;
                end else if (segmented_i &&
                        req_i.addr_reg == DMSP_STACK_SEG_REG) begin
                    new_seg = req_i.wdata;
                    wr_seg = 1'b1;
                end else begin
                    bad = 1'b1;
                end
            end
            DMSP_OP_LDCTL_WR: begin
                new_off = norm_off;
                new_seg = norm_seg;
                case (req_i.sel)
                    DMSP_SEL_WORD: begin
                        new_off = req_i.wdata;
                        bad = segmented_i;
                    end
                    DMSP_SEL_OFFSET: begin
                        new_off = req_i.wdata;
                        bad = !segmented_i;
                    end
                    DMSP_SEL_SEGMENT: begin
                        new_seg = req_i.wdata;
                        wr_seg = 1'b1;
                        bad = !segmented_i;
                    end
                    default: begin
                        bad = 1'b1;
                    end
                endcase
                if (!privileged_i) begin
                    bad = 1'b1;
                end
            end
            default: begin
            end
        endcase
        if (access && acc_addr[0]) begin
            bad = 1'b1;
            access = 1'b0;
        end
        if (take && !bad && req_i.op != DMSP_OP_NONE &&
                req_i.op != DMSP_OP_MEM) begin
            if (req_i.op == DMSP_OP_LDCTL_WR) begin
                wr_norm = 1'b1;
            end else begin
                // call uses mode copy, traps never
                wr_sys = use_sys;
                wr_norm = !use_sys;
            end
        end
        if (!take || bad) begin
            wr_seg = 1'b0;
        end
        // no byte sized stack operation exists
    end

    // ********************************************************
    // status code output
    // ********************************************************
    logic [3:0] status;
    logic stack_ref;

    dmsp_status_enc u_status (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .access_i(take && access),
        .stack_via_sp_i(via_sp),
        .status_o(status),
        .stack_ref_o(stack_ref)
    );

    // ********************************************************
    // bus cycle registers
    // ********************************************************
    logic bus_valid_q;
    logic bus_write_q;
    logic [W-1:0] bus_addr_q;
    logic [W-1:0] bus_seg_q;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            bus_valid_q <= 1'b0;
            bus_write_q <= 1'b0;
            bus_addr_q <= '0;
            bus_seg_q <= '0;
        end else if (ce_i) begin
            bus_valid_q <= take && access;
            bus_write_q <= take && access && acc_wr;
            if (take && access) begin
                bus_addr_q <= acc_addr;
                bus_seg_q <= acc_seg;
            end
        end
    end

    always_comb begin
        bus_o.valid = bus_valid_q;
        bus_o.write = bus_write_q;
        bus_o.stack_ref = stack_ref;
        bus_o.seg = bus_seg_q;
        bus_o.addr = bus_addr_q;
        bus_o.status = status;
    end

    // ********************************************************
    // completion, readback, interrupt acceptance
    // ********************************************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            req_done_o <= 1'b0;
            req_err_o <= 1'b0;
            rdata_o <= '0;
        end else if (ce_i) begin
            req_done_o <= take && !bad;
            req_err_o <= take && bad;
            // readback shows the current-mode offset
            rdata_o <= cur_off;
        end
    end

    // accept at instruction or iteration boundary
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            irq_ack_o <= 1'b0;
        end else if (ce_i) begin
            irq_ack_o <= irq_i && boundary_i;
        end
    end
endmodule : dmsp_top
`default_nettype wire

/* File: testbench/dmsp_mem_model.sv */
// dmsp_mem_model: memory system steered by the bus status lines
`timescale 1ns/1ps
`default_nettype none
module dmsp_mem_model (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire dmsp_pkg::dmsp_bus_t bus_i,
    output logic [15:0] stack_cnt_o,
    output logic [15:0] data_cnt_o
);
    import dmsp_pkg::*;

    // ********************************************************
    // steering by status
    // ********************************************************
    // only the status code picks the bank, never the address
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            stack_cnt_o <= 16'h0000;
            data_cnt_o <= 16'h0000;
        end else if (bus_i.valid && bus_i.status == DMSP_ST_STACK) begin
            stack_cnt_o <= stack_cnt_o + 16'h0001;
        end else if (bus_i.valid && bus_i.status == DMSP_ST_DATA) begin
            data_cnt_o <= data_cnt_o + 16'h0001;
        end
    end
endmodule : dmsp_mem_model
`default_nettype wire

/* File: testbench/dmsp_checker.sv */
// dmsp_checker: port assertions for the dual-mode stack pointer
`timescale 1ns/1ps
`default_nettype none
module dmsp_checker #(
    parameter int unsigned W = 16
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire dmsp_pkg::dmsp_req_t req_i,
    input wire logic privileged_i,
    input wire logic segmented_i,
    input wire logic boundary_i,
    input wire logic irq_i,
    input wire logic req_done_o,
    input wire logic req_err_o,
    input wire logic irq_ack_o,
    input wire dmsp_pkg::dmsp_bus_t bus_o,
    input wire logic [W-1:0] rdata_o
);
    import dmsp_pkg::*;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    // ********************************************************
    // assertions
    // ********************************************************
    a_push_no_bound: assert property (
        ce_i && req_valid_i && req_i.op == DMSP_OP_PUSH
        |=> req_done_o && !req_err_o) else $error("push refused");
    a_push_pre_dec: assert property (
        ce_i && req_valid_i && req_i.op == DMSP_OP_PUSH && !req_i.long_op
        |=> bus_o.write && bus_o.addr == rdata_o - 16'h0002)
        else $error("push address not decremented first");
    a_pop_post_inc: assert property (
        ce_i && req_valid_i && req_i.op == DMSP_OP_POP
        |=> !bus_o.write && bus_o.addr == rdata_o)
        else $error("pop address not the old pointer");
    a_stack_status: assert property (
        ce_i && req_valid_i && req_i.op == DMSP_OP_MEM && req_i.base_mode
        && req_i.addr_reg == DMSP_STACK_WORD_REG && !req_i.addr_in[0]
        |=> bus_o.status == DMSP_ST_STACK) else $error("stack status missing");
    a_data_status: assert property (
        ce_i && req_valid_i && req_i.op == DMSP_OP_MEM && !req_i.addr_in[0]
        && req_i.addr_reg != DMSP_STACK_WORD_REG
        && req_i.addr_reg != DMSP_STACK_SEG_REG
        |=> bus_o.status == DMSP_ST_DATA) else $error("data status missing");
    a_even_word_addr: assert property (
        bus_o.valid |-> !bus_o.addr[0]) else $error("odd word address");
    a_irq_boundary: assert property (
        ce_i |=> irq_ack_o == $past(irq_i && boundary_i))
        else $error("interrupt not taken at boundary");
    a_refuse_no_bus: assert property (
        req_err_o |-> !bus_o.valid && !req_done_o)
        else $error("refused request reached the bus");
    a_ldctl_unpriv: assert property (
        ce_i && req_valid_i && req_i.op == DMSP_OP_LDCTL_WR && !privileged_i
        |=> req_err_o) else $error("unprivileged control load accepted");
    a_trap_stack: assert property (
        ce_i && req_valid_i && req_i.op == DMSP_OP_TRAP
        |=> bus_o.valid && bus_o.write && bus_o.stack_ref)
        else $error("trap did not push on stack");

    c_push: cover property (ce_i && req_valid_i && req_i.op == DMSP_OP_PUSH);
    c_trap_unpriv: cover property (req_valid_i && req_i.op == DMSP_OP_TRAP
        && !privileged_i);
    c_irq_ack: cover property (irq_ack_o);
    c_refused: cover property (req_err_o);
endmodule : dmsp_checker

bind dmsp_top dmsp_checker #(.W(W)) i_dmsp_checker (
    .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .privileged_i(privileged_i),
    .segmented_i(segmented_i), .boundary_i(boundary_i), .irq_i(irq_i),
    .req_done_o(req_done_o), .req_err_o(req_err_o), .irq_ack_o(irq_ack_o),
    .bus_o(bus_o), .rdata_o(rdata_o));
`default_nettype wire

/* File: testbench/dmsp_top_tb.sv */
// dmsp_top_tb: directed scenarios for the dual-mode stack pointer
`timescale 1ns/1ps
`default_nettype none
module dmsp_top_tb;
    import dmsp_pkg::*;
    logic clock_i, srst_i, ce_i, req_valid_i, privileged_i, segmented_i;
    logic boundary_i, irq_i, req_done_o, req_err_o, irq_ack_o;
    dmsp_req_t req_i;
    dmsp_bus_t bus_o;
    logic [15:0] rdata_o, stack_cnt, data_cnt;
    int err_count = 0;
    int total_checks = 0;

    dmsp_top #(.W(16)) i_dmsp_top (.clock_i(clock_i), .srst_i(srst_i),
        .ce_i(ce_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .privileged_i(privileged_i), .segmented_i(segmented_i),
        .boundary_i(boundary_i), .irq_i(irq_i), .req_done_o(req_done_o),
        .req_err_o(req_err_o), .irq_ack_o(irq_ack_o), .bus_o(bus_o),
        .rdata_o(rdata_o));
    dmsp_mem_model i_dmsp_mem_model (.clock_i(clock_i), .srst_i(srst_i),
        .bus_i(bus_o), .stack_cnt_o(stack_cnt), .data_cnt_o(data_cnt));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
            input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // idle e_st means no bus cycle is expected
    task automatic xfer(input dmsp_op_t op, input logic lng,
            input logic [3:0] rg, input dmsp_sel_t sl, input logic [15:0] wd,
            input logic [15:0] ai, input logic e_err, input logic [15:0] e_ad,
            input logic [3:0] e_st);
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_i <= '{op: op, long_op: lng, addr_reg: rg, base_mode: 1'b1,
            sel: sl, wdata: wd, addr_in: ai};
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        #1;
        chk(16'(req_err_o), 16'(e_err), "refusal");
        chk(16'(req_done_o), 16'(!e_err), "accept");
        chk(16'(bus_o.valid), 16'(e_st != DMSP_ST_IDLE), "valid");
        if (e_st != DMSP_ST_IDLE) begin
            chk(bus_o.addr, e_ad, "address");
            chk(16'(bus_o.status), 16'(e_st), "status");
        end
    endtask : xfer

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_push_pop();
        xfer(DMSP_OP_PUSH, 0, 4'hf, DMSP_SEL_WORD, 16'h1234, 0, 0, 16'hfffe, DMSP_ST_STACK);
        xfer(DMSP_OP_PUSH, 1, 4'hf, DMSP_SEL_WORD, 16'h5678, 0, 0, 16'hfffa, DMSP_ST_STACK);
        xfer(DMSP_OP_POP, 1, 4'hf, DMSP_SEL_WORD, 0, 0, 0, 16'hfffa, DMSP_ST_STACK);
        xfer(DMSP_OP_MEM, 0, 4'hf, DMSP_SEL_WORD, 0, 16'h0004, 0, 16'h0002, DMSP_ST_STACK);
        xfer(DMSP_OP_MEM, 0, 4'h3, DMSP_SEL_WORD, 0, 16'h0010, 0, 16'h0010, DMSP_ST_DATA);
        xfer(DMSP_OP_MEM, 0, 4'h3, DMSP_SEL_WORD, 0, 16'h0011, 1, 0, DMSP_ST_IDLE);
    endtask : t_push_pop

    task automatic t_modes();
        @(posedge clock_i) privileged_i <= 1'b0;
        xfer(DMSP_OP_CALL, 0, 4'hf, DMSP_SEL_WORD, 16'h0400, 0, 0, 16'hfffe, DMSP_ST_STACK);
        xfer(DMSP_OP_TRAP, 0, 4'hf, DMSP_SEL_WORD, 16'h0500, 0, 0, 16'hfffc, DMSP_ST_STACK);
        xfer(DMSP_OP_RET, 0, 4'hf, DMSP_SEL_WORD, 0, 0, 0, 16'hfffe, DMSP_ST_STACK);
        xfer(DMSP_OP_LDCTL_WR, 0, 4'hf, DMSP_SEL_WORD, 16'h0300, 0, 1, 0, DMSP_ST_IDLE);
        xfer(DMSP_OP_REG_WR, 0, 4'hf, DMSP_SEL_WORD, 16'h0100, 0, 0, 0, DMSP_ST_IDLE);
        xfer(DMSP_OP_PUSH, 0, 4'hf, DMSP_SEL_WORD, 16'h0007, 0, 0, 16'h00fe, DMSP_ST_STACK);
        @(posedge clock_i) privileged_i <= 1'b1;
        xfer(DMSP_OP_LDCTL_WR, 0, 4'hf, DMSP_SEL_WORD, 16'h0200, 0, 0, 0, DMSP_ST_IDLE);
        xfer(DMSP_OP_POP, 0, 4'hf, DMSP_SEL_WORD, 0, 0, 0, 16'hfffc, DMSP_ST_STACK);
        @(posedge clock_i) privileged_i <= 1'b0;
        xfer(DMSP_OP_POP, 0, 4'hf, DMSP_SEL_WORD, 0, 0, 0, 16'h0200, DMSP_ST_STACK);
    endtask : t_modes

    task automatic t_segmented();
        @(posedge clock_i) privileged_i <= 1'b1;
        segmented_i <= 1'b1;
        xfer(DMSP_OP_LDCTL_WR, 0, 4'hf, DMSP_SEL_WORD, 16'h0009, 0, 1, 0, DMSP_ST_IDLE);
        xfer(DMSP_OP_REG_WR, 0, 4'he, DMSP_SEL_WORD, 16'h0006, 0, 0, 0, DMSP_ST_IDLE);
        xfer(DMSP_OP_LDCTL_WR, 0, 4'hf, DMSP_SEL_SEGMENT, 16'h0009, 0, 0, 0, DMSP_ST_IDLE);
        xfer(DMSP_OP_PUSH, 0, 4'hf, DMSP_SEL_WORD, 16'h0001, 0, 0, 16'hfffc, DMSP_ST_STACK);
        chk(bus_o.seg, 16'h0006, "privileged segment");
        @(posedge clock_i) privileged_i <= 1'b0;
        xfer(DMSP_OP_PUSH, 0, 4'hf, DMSP_SEL_WORD, 16'h0002, 0, 0, 16'h0200, DMSP_ST_STACK);
        chk(bus_o.seg, 16'h0009, "unprivileged segment");
    endtask : t_segmented

    task automatic t_irq();
        @(posedge clock_i);
        irq_i <= 1'b1;
        boundary_i <= 1'b1;
        @(posedge clock_i);
        boundary_i <= 1'b0;
        #1;
        chk(16'(irq_ack_o), 16'h0001, "ack at boundary");
        @(posedge clock_i);
        irq_i <= 1'b0;
        #1;
        chk(16'(irq_ack_o), 16'h0000, "ack inside instruction");
        // unprivileged copy left at 0200 by the segmented push
        chk(rdata_o, 16'h0200, "current copy readback");
    endtask : t_irq

    // ********************************************************
    // main sequence and watchdog
    // ********************************************************
    initial begin
        srst_i = 1'b1;
        ce_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        privileged_i = 1'b1;
        segmented_i = 1'b0;
        boundary_i = 1'b0;
        irq_i = 1'b0;
        repeat (4) @(posedge clock_i);
        srst_i <= 1'b0;
        t_push_pop();
        t_modes();
        t_segmented();
        t_irq();
        @(posedge clock_i);
        #1;
        // status alone steers the far-side banks
        chk(stack_cnt, 16'h000c, "stack bank hits");
        chk(data_cnt, 16'h0001, "data bank hits");
        results();
    end

    // a whole run needs about 55 cycles
    initial begin
        repeat (2000) @(posedge clock_i);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
endmodule : dmsp_top_tb
`default_nettype wire
